// ---- fsc_pkg.sv ----
// Shared opcodes, bit positions, reset values and timing for the flash status block
package fsc_pkg;
	localparam logic [7:0] OP_WREN      = 8'h06;
	localparam logic [7:0] OP_WRDI      = 8'h04;
	localparam logic [7:0] OP_RDSR1     = 8'h05;
	localparam logic [7:0] OP_RDSR2     = 8'h35;
	localparam logic [7:0] OP_RDSR3     = 8'h15;
	localparam logic [7:0] OP_WRSR1     = 8'h01;
	localparam logic [7:0] OP_WRSR2     = 8'h31;
	localparam logic [7:0] OP_WRSR3     = 8'h11;
	localparam logic [7:0] OP_PROG      = 8'h02;
	localparam logic [7:0] OP_QPROG     = 8'h32;
	localparam logic [7:0] OP_SEC_ERASE = 8'h20;
	localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHP_ERASE = 8'hC7;
	localparam logic [7:0] OP_SR_ERASE  = 8'h44;
	localparam logic [7:0] OP_SR_PROG   = 8'h42;
	localparam logic [7:0] OP_SUSPEND   = 8'h75;
	localparam logic [7:0] OP_RESUME    = 8'h7A;
	localparam logic [7:0] OP_QUAD_ON   = 8'h38;
	localparam logic [7:0] OP_QUAD_OFF  = 8'hFF;
	localparam logic [7:0] OP_ADDR4_ON  = 8'hB7;
	localparam logic [7:0] OP_ADDR4_OFF = 8'hE9;
	localparam logic [7:0] OP_OTP_PRE1  = 8'hAA;
	localparam logic [7:0] OP_OTP_PRE2  = 8'h55;
	// Status byte one
	localparam int B_BUSY   = 0;
	localparam int B_WEL    = 1;
	localparam int B_BP_LO  = 2;
	localparam int B_BP_HI  = 5;
	localparam int B_TB     = 6;
	localparam int B_SRP    = 7;
	// Status byte two
	localparam int B_SRL    = 0;
	localparam int B_QE     = 1;
	localparam int B_LB_LO  = 3;
	localparam int B_LB_HI  = 5;
	localparam int B_CMP    = 6;
	localparam int B_SUS    = 7;
	// Status byte three
	localparam int B_ADS    = 0;
	localparam int B_DRV_LO = 5;
	localparam int B_DRV_HI = 6;
	localparam logic [1:0] DRV_RESET = 2'h1;
	localparam logic [2:0] LAST_BIT  = 3'h7;
	localparam logic [1:0] NB_MAX    = 2'h3;
	// Operation times
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned T_WRITE_US    = 5000;
	localparam int unsigned T_PROG_US     = 500;
	localparam int unsigned T_ERASE_US    = 50000;
	localparam int unsigned WRITE_CYC = (T_WRITE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PROG_CYC  = (T_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ERASE_CYC = (T_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : fsc_pkg

// ---- fsc_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for pins
`timescale 1ns/10ps
module fsc_pin_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] lvl_reg;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Only bits on which stages two and three agree move the level
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			lvl_reg <= RST_VAL;
		end else begin
			lvl_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (lvl_reg & (s2_reg ^ s3_reg));
		end
	end

	assign o_level = lvl_reg;
endmodule : fsc_pin_sync

// ---- fsc_op_timer.sv ----
// Pausable down counter that times internal program, erase and write operations
`timescale 1ns/10ps
module fsc_op_timer (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_start,
	input  wire logic [31:0] i_load,
	input  wire logic        i_pause,
	output logic             o_running,
	output logic             o_done
);
	logic [31:0] cnt_reg;
	logic        run_reg;
	logic        done_reg;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cnt_reg  <= 32'h0;
			run_reg  <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (i_start) begin
				cnt_reg <= i_load;
				run_reg <= 1'b1;
			end else if (run_reg && !i_pause) begin
				if (cnt_reg <= 32'h1) begin
					run_reg  <= 1'b0;
					done_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 32'h1;
				end
			end
		end
	end

	assign o_running = run_reg;
	assign o_done    = done_reg;
endmodule : fsc_op_timer

// ---- fsc_status_regs.sv ----
// Serial flash status and configuration registers behind the serial command pins
// Function
// - Three status bytes, each with read command
// - Busy bit high during internal operations
// - Busy ignores all but status read, suspend
// - Busy clears when operation finishes
// - Write enable sets read-only latch flag
// - Latch flag cleared by disable, program, erase, write
// - Four block guard bits, writable, reset zero
// - Bottom-select bit picks range end
// - Complement bit swaps protected portion
// - Protect pin matters only outside quad use
// - Mode zero: writes need only latch flag
// - Guard mode, pin low: writes refused
// - Guard mode, pin high: latch flag suffices
// - Lockdown refuses writes until power cycle
// - Prefix pair before write locks until power cycle
// - Suspend flag set by suspend, cleared resume
// - Secure area locks set once, clear only at power cycle
// - Quad enable turns pin functions off
// - Quad command mode needs quad enable
// - Quad command mode keeps quad enable set
// - Read-only address width bit
// - Two-bit drive strength, default three quarters
`timescale 1ns/10ps
module fsc_status_regs #(
	parameter int unsigned WRITE_CYCLES = fsc_pkg::WRITE_CYC,
	parameter int unsigned PROG_CYCLES  = fsc_pkg::PROG_CYC,
	parameter int unsigned ERASE_CYCLES = fsc_pkg::ERASE_CYC
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_sclk,
	input  wire logic       i_cs_b,
	input  wire logic       i_di,
	input  wire logic       i_wp_b,
	output logic            o_do,
	output logic            o_do_oe_b,
	output logic [7:0]      o_status_one,
	output logic [7:0]      o_status_two,
	output logic [7:0]      o_status_three,
	output logic            o_quad_command_mode,
	output logic            o_pin_funcs_on,
	output logic [1:0]      o_drive_strength,
	output logic            o_otp_locked
);
	typedef enum logic [2:0] {FRM_IDLE, FRM_OPCODE, FRM_DATA, FRM_READ, FRM_SKIP} fsc_frm_t;

	fsc_frm_t   state_reg;
	logic       sclk_s, cs_b_s, di_s, wp_b_s, sclk_d_reg;
	logic [7:0] shift_reg, op_reg, d0_reg, d1_reg, rd_reg;
	logic [2:0] bit_cnt_reg, rd_cnt_reg;
	logic [1:0] nbytes_reg;
	logic       busy_reg, wel_reg, tb_reg, srp_reg, srl_reg, qe_reg, cmp_reg, sus_reg;
	logic [3:0] bp_reg;
	logic [2:0] lb_reg;
	logic       ads_reg, qpi_reg, otp_reg, arr_op_reg;
	logic [1:0] drv_reg, pre_reg;
	logic       do_reg, do_oe_b_reg, pins_reg, otp_out_reg;
	logic [7:0] st1_reg, st2_reg, st3_reg;
	logic [7:0] byte_in, rd_now;
	logic       sclk_rise, sclk_fall, frame_end, cmd_ok;
	logic       ex_wren, ex_wrdi, ex_sr1, ex_sr2, ex_sr3, ex_arr, ex_erase;
	logic       ex_susp, ex_resume, ex_qon, ex_qoff, ex_a4on, ex_a4off, ex_pre1, ex_pre2;
	logic [7:0] sr2_data;
	logic       sr_ok, wr_go, arr_go, tmr_start, tmr_done;
	logic [31:0] tmr_load;

	// Reset levels match the idle pins, so no false clock edge follows reset
	fsc_pin_sync #(.W(4), .RST_VAL(4'hC)) u_sync (
		.i_clk   (i_core_clk),
		.i_rst_b (i_rst_b),
		.i_pin   ({i_wp_b, i_cs_b, i_sclk, i_di}),
		.o_level ({wp_b_s, cs_b_s, sclk_s, di_s})
	);

	fsc_op_timer u_timer (
		.i_clk     (i_core_clk),
		.i_rst_b   (i_rst_b),
		.i_start   (tmr_start),
		.i_load    (tmr_load),
		.i_pause   (sus_reg),
		.o_running (),
		.o_done    (tmr_done)
	);

	function automatic logic [7:0] status_of(input logic [7:0] op, input logic [7:0] s1,
		input logic [7:0] s2, input logic [7:0] s3);
		case (op)
			fsc_pkg::OP_RDSR1: status_of = s1;
			fsc_pkg::OP_RDSR2: status_of = s2;
			fsc_pkg::OP_RDSR3: status_of = s3;
			default:           status_of = 8'h00;
		endcase
	endfunction : status_of

	function automatic logic is_read(input logic [7:0] op);
		is_read = (op == fsc_pkg::OP_RDSR1) || (op == fsc_pkg::OP_RDSR2) ||
			(op == fsc_pkg::OP_RDSR3);
	endfunction : is_read

	logic [7:0] s1_now, s2_now, s3_now;
	assign s1_now = {srp_reg, tb_reg, bp_reg, wel_reg, busy_reg};
	assign s2_now = {sus_reg, cmp_reg, lb_reg, 1'b0, qe_reg, srl_reg};
	assign s3_now = {1'b0, drv_reg, 4'h0, ads_reg};
	assign rd_now = status_of(op_reg, s1_now, s2_now, s3_now);

	assign byte_in   = {shift_reg[6:0], di_s};
	assign sclk_rise = sclk_s & ~sclk_d_reg;
	assign sclk_fall = ~sclk_s & sclk_d_reg;
	assign frame_end = cs_b_s && (state_reg != FRM_IDLE);
	// Commands act only when the frame ends on a byte boundary
	assign cmd_ok    = frame_end && (state_reg == FRM_DATA) && (bit_cnt_reg == 3'h0);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_s;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			state_reg   <= FRM_IDLE;
			shift_reg   <= 8'h00;
			op_reg      <= 8'h00;
			d0_reg      <= 8'h00;
			d1_reg      <= 8'h00;
			bit_cnt_reg <= 3'h0;
			nbytes_reg  <= 2'h0;
		end else if (cs_b_s) begin
			state_reg <= FRM_IDLE;
		end else if (state_reg == FRM_IDLE) begin
			state_reg   <= FRM_OPCODE;
			bit_cnt_reg <= 3'h0;
			nbytes_reg  <= 2'h0;
		end else if (sclk_rise) begin
			shift_reg   <= byte_in;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == fsc_pkg::LAST_BIT) begin
				if (state_reg == FRM_OPCODE) begin
					op_reg <= byte_in;
					if (busy_reg && !is_read(byte_in) && byte_in != fsc_pkg::OP_SUSPEND) begin
						state_reg <= FRM_SKIP;
					end else if (is_read(byte_in)) begin
						state_reg <= FRM_READ;
					end else begin
						state_reg <= FRM_DATA;
					end
				end else if (state_reg == FRM_DATA) begin
					if (nbytes_reg == 2'h0) begin
						d0_reg <= byte_in;
					end else if (nbytes_reg == 2'h1) begin
						d1_reg <= byte_in;
					end
					if (nbytes_reg != fsc_pkg::NB_MAX) begin
						nbytes_reg <= nbytes_reg + 2'h1;
					end
				end
			end
		end
	end

	// Status is re-sampled every byte so a polling host sees busy fall
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			rd_reg      <= 8'h00;
			rd_cnt_reg  <= 3'h0;
			do_reg      <= 1'b0;
			do_oe_b_reg <= 1'b1;
		end else if (state_reg != FRM_READ || cs_b_s) begin
			rd_cnt_reg  <= 3'h0;
			do_oe_b_reg <= 1'b1;
		end else if (sclk_fall) begin
			do_oe_b_reg <= 1'b0;
			rd_cnt_reg  <= rd_cnt_reg + 3'h1;
			do_reg <= (rd_cnt_reg == 3'h0) ? rd_now[7] : rd_reg[7];
			rd_reg <= (rd_cnt_reg == 3'h0) ? {rd_now[6:0], 1'b0} : {rd_reg[6:0], 1'b0};
		end
	end

	assign ex_wren   = cmd_ok && (op_reg == fsc_pkg::OP_WREN) && (nbytes_reg == 2'h0);
	assign ex_wrdi   = cmd_ok && (op_reg == fsc_pkg::OP_WRDI);
	assign ex_sr1    = cmd_ok && (op_reg == fsc_pkg::OP_WRSR1) && (nbytes_reg != 2'h0);
	assign ex_sr2    = cmd_ok && (((op_reg == fsc_pkg::OP_WRSR2) && (nbytes_reg != 2'h0)) ||
		((op_reg == fsc_pkg::OP_WRSR1) && (nbytes_reg >= 2'h2)));
	assign ex_sr3    = cmd_ok && (op_reg == fsc_pkg::OP_WRSR3) && (nbytes_reg != 2'h0);
	assign ex_erase  = cmd_ok && ((op_reg == fsc_pkg::OP_SEC_ERASE) ||
		(op_reg == fsc_pkg::OP_BLK_ERASE) || (op_reg == fsc_pkg::OP_CHP_ERASE) ||
		(op_reg == fsc_pkg::OP_SR_ERASE));
	assign ex_arr    = ex_erase || (cmd_ok && ((op_reg == fsc_pkg::OP_PROG) ||
		(op_reg == fsc_pkg::OP_QPROG) || (op_reg == fsc_pkg::OP_SR_PROG)));
	assign ex_susp   = cmd_ok && (op_reg == fsc_pkg::OP_SUSPEND);
	assign ex_resume = cmd_ok && (op_reg == fsc_pkg::OP_RESUME);
	assign ex_qon    = cmd_ok && (op_reg == fsc_pkg::OP_QUAD_ON);
	assign ex_qoff   = cmd_ok && (op_reg == fsc_pkg::OP_QUAD_OFF);
	assign ex_a4on   = cmd_ok && (op_reg == fsc_pkg::OP_ADDR4_ON);
	assign ex_a4off  = cmd_ok && (op_reg == fsc_pkg::OP_ADDR4_OFF);
	assign ex_pre1   = cmd_ok && (op_reg == fsc_pkg::OP_OTP_PRE1);
	assign ex_pre2   = cmd_ok && (op_reg == fsc_pkg::OP_OTP_PRE2);
	assign sr2_data  = (op_reg == fsc_pkg::OP_WRSR1) ? d1_reg : d0_reg;

	// The protect pin is a data line once quad enable is set
	assign sr_ok = wel_reg && !srl_reg && !otp_reg && (!srp_reg || qe_reg || wp_b_s);
	assign wr_go = (ex_sr1 || ex_sr2 || ex_sr3) && sr_ok && !sus_reg;
	assign arr_go = ex_arr && wel_reg && !sus_reg;
	assign tmr_start = wr_go || arr_go;
	assign tmr_load = !arr_go ? 32'(WRITE_CYCLES) :
		(ex_erase ? 32'(ERASE_CYCLES) : 32'(PROG_CYCLES));

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			wel_reg <= 1'b0;
		end else if (ex_wren) begin
			wel_reg <= 1'b1;
		end else if (ex_wrdi || wr_go || arr_go) begin
			wel_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			busy_reg   <= 1'b0;
			sus_reg    <= 1'b0;
			arr_op_reg <= 1'b0;
		end else if (tmr_start) begin
			busy_reg   <= 1'b1;
			arr_op_reg <= arr_go;
		end else if (tmr_done) begin
			busy_reg <= 1'b0;
		end else if (ex_susp && busy_reg && arr_op_reg && !sus_reg) begin
			busy_reg <= 1'b0;
			sus_reg  <= 1'b1;
		end else if (ex_resume && sus_reg) begin
			busy_reg <= 1'b1;
			sus_reg  <= 1'b0;
		end
	end

	// Refused writes fall through with every field held
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			bp_reg  <= 4'h0;
			tb_reg  <= 1'b0;
			srp_reg <= 1'b0;
			srl_reg <= 1'b0;
			qe_reg  <= 1'b0;
			lb_reg  <= 3'h0;
			cmp_reg <= 1'b0;
			drv_reg <= fsc_pkg::DRV_RESET;
		end else if (wr_go) begin
			if (ex_sr1) begin
				bp_reg  <= d0_reg[fsc_pkg::B_BP_HI:fsc_pkg::B_BP_LO];
				tb_reg  <= d0_reg[fsc_pkg::B_TB];
				srp_reg <= d0_reg[fsc_pkg::B_SRP];
			end
			if (ex_sr2) begin
				srl_reg <= sr2_data[fsc_pkg::B_SRL];
				qe_reg  <= sr2_data[fsc_pkg::B_QE] || qpi_reg;
				lb_reg  <= lb_reg | sr2_data[fsc_pkg::B_LB_HI:fsc_pkg::B_LB_LO];
				cmp_reg <= sr2_data[fsc_pkg::B_CMP];
			end
			if (ex_sr3) begin
				drv_reg <= d0_reg[fsc_pkg::B_DRV_HI:fsc_pkg::B_DRV_LO];
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			qpi_reg <= 1'b0;
			ads_reg <= 1'b0;
		end else begin
			if (ex_qon && qe_reg) begin
				qpi_reg <= 1'b1;
			end else if (ex_qoff) begin
				qpi_reg <= 1'b0;
			end
			if (ex_a4on) begin
				ads_reg <= 1'b1;
			end else if (ex_a4off) begin
				ads_reg <= 1'b0;
			end
		end
	end

	// Prefix survives a write enable so the usual enable-then-write order works
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			pre_reg <= 2'h0;
			otp_reg <= 1'b0;
		end else begin
			if (wr_go && pre_reg == 2'h2) begin
				otp_reg <= 1'b1;
			end
			if (ex_pre1) begin
				pre_reg <= 2'h1;
			end else if (ex_pre2) begin
				pre_reg <= (pre_reg == 2'h1) ? 2'h2 : 2'h0;
			end else if (cmd_ok && !ex_wren) begin
				pre_reg <= 2'h0;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			st1_reg     <= 8'h00;
			st2_reg     <= 8'h00;
			st3_reg     <= 8'h00;
			pins_reg    <= 1'b1;
			otp_out_reg <= 1'b0;
		end else begin
			st1_reg     <= status_of(fsc_pkg::OP_RDSR1, s1_now, s2_now, s3_now);
			st2_reg     <= status_of(fsc_pkg::OP_RDSR2, s1_now, s2_now, s3_now);
			st3_reg     <= status_of(fsc_pkg::OP_RDSR3, s1_now, s2_now, s3_now);
			pins_reg    <= !qe_reg;
			otp_out_reg <= otp_reg;
		end
	end

	assign o_do                = do_reg;
	assign o_do_oe_b           = do_oe_b_reg;
	assign o_status_one        = st1_reg;
	assign o_status_two        = st2_reg;
	assign o_status_three      = st3_reg;
	assign o_quad_command_mode = qpi_reg;
	assign o_pin_funcs_on      = pins_reg;
	assign o_drive_strength    = drv_reg;
	assign o_otp_locked        = otp_out_reg;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	chk_busy_gate: assert property (state_reg == FRM_OPCODE && sclk_rise &&
		bit_cnt_reg == fsc_pkg::LAST_BIT && busy_reg && !is_read(byte_in) &&
		byte_in != fsc_pkg::OP_SUSPEND |=> state_reg == FRM_SKIP)
		else $error("command taken while busy");
	chk_busy_start: assert property (tmr_start |=> busy_reg && !wel_reg)
		else $error("busy or latch wrong after start");
	chk_busy_end: assert property (tmr_done && !tmr_start |=> !busy_reg)
		else $error("busy not cleared at end");
	chk_wel_set: assert property (ex_wren |=> wel_reg ##1 wel_reg)
		else $error("latch flag not set");
	chk_wel_clear: assert property (ex_wrdi |=> !wel_reg)
		else $error("latch flag not cleared");
	chk_wp_refuse: assert property (ex_sr1 && srp_reg && !qe_reg && !wp_b_s
		|=> $stable(bp_reg) && $stable(srp_reg) && !busy_reg)
		else $error("write taken with pin low");
	chk_lock_refuse: assert property (srl_reg && (ex_sr1 || ex_sr2)
		|=> $stable(bp_reg) && $stable(cmp_reg) && srl_reg)
		else $error("write taken under lockdown");
	chk_noguard_ok: assert property ((ex_sr1 && !srp_reg && !srl_reg && !otp_reg
		&& wel_reg && !sus_reg) |=> bp_reg == $past(d0_reg[fsc_pkg::B_BP_HI:fsc_pkg::B_BP_LO]))
		else $error("unguarded write lost");
	chk_lb_sticky: assert property (##1 ($past(lb_reg) & ~lb_reg) == 3'h0)
		else $error("lock bit cleared");
	chk_quad_gate: assert property (ex_qon && !qe_reg && !qpi_reg |=> !qpi_reg)
		else $error("quad mode without enable");
	chk_quad_keep: assert property (qpi_reg |-> qe_reg)
		else $error("quad enable lost in quad mode");
	chk_suspend: assert property (ex_susp && busy_reg && arr_op_reg && !sus_reg
		&& !tmr_done |=> sus_reg && !busy_reg)
		else $error("suspend not taken");
endmodule : fsc_status_regs

// ---- fsc_host_model.sv ----
// Host serial controller model that drives command frames into the flash status block
`timescale 1ns/10ps
module fsc_host_model (
	input  wire logic i_do,
	input  wire logic i_do_oe_b,
	output logic      o_sclk,
	output logic      o_cs_b,
	output logic      o_di
);
	logic oe_seen;

	// Mode 0: the clock idles low and stands still between frames
	initial begin
		o_sclk  = 1'b0;
		o_cs_b  = 1'b1;
		o_di    = 1'b0;
		oe_seen = 1'b0;
	end

	// Sample the reply just before the rising edge, half a period after the device moved it
	task automatic shift(input logic [7:0] b, inout logic [7:0] rd);
		for (int i = 7; i >= 0; i--) begin
			o_di = b[i];
			#80;
			rd = {rd[6:0], i_do};
			if (i_do_oe_b === 1'b0) begin
				oe_seen = 1'b1;
			end
			o_sclk = 1'b1;
			#80;
			o_sclk = 1'b0;
		end
	endtask : shift

	task automatic frame(input logic [7:0] op, input logic [7:0] d0, input int n,
			output logic [7:0] rd);
		rd      = 8'h00;
		oe_seen = 1'b0;
		o_cs_b  = 1'b0;
		#80;
		shift(op, rd);
		if (n > 0) begin
			shift(d0, rd);
		end
		#40;
		o_cs_b = 1'b1;
		// A released data line shows the inverse, never a stale bit
		o_di = ~o_di;
		#240;
	endtask : frame

	// Two prefix frames must come before the status write that seals the registers
	task automatic seal_prefix();
		logic [7:0] rd;
		frame(fsc_pkg::OP_OTP_PRE1, 8'h00, 0, rd);
		frame(fsc_pkg::OP_OTP_PRE2, 8'h00, 0, rd);
	endtask : seal_prefix
endmodule : fsc_host_model

// ---- testbench.sv ----
// Self-checking bench for the flash status and configuration registers
`timescale 1ns/10ps
module testbench;
	logic       i_core_clk;
	logic       i_rst_b;
	logic       i_wp_b;
	logic       sclk;
	logic       cs_b;
	logic       di;
	logic       do_bit;
	logic       do_oe_b;
	logic [7:0] st1;
	logic [7:0] st2;
	logic [7:0] st3;
	logic       qmode;
	logic       pins_on;
	logic [1:0] drv;
	logic       otp;
	logic [7:0] rd;
	logic [7:0] rnd;
	logic [7:0] e2;
	logic [7:0] e3;
	int         errors;
	int         tests_run;
	int         seed;

	// Short operation times keep busy visible across one frame yet the run brief
	fsc_status_regs #(.WRITE_CYCLES(300), .PROG_CYCLES(200), .ERASE_CYCLES(400)) dut_u (
		.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_cs_b(cs_b),
		.i_di(di), .i_wp_b(i_wp_b), .o_do(do_bit), .o_do_oe_b(do_oe_b),
		.o_status_one(st1), .o_status_two(st2), .o_status_three(st3),
		.o_quad_command_mode(qmode), .o_pin_funcs_on(pins_on),
		.o_drive_strength(drv), .o_otp_locked(otp));
	fsc_host_model host_u (.i_do(do_bit), .i_do_oe_b(do_oe_b), .o_sclk(sclk), .o_cs_b(cs_b),
		.o_di(di));

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	function automatic logic [7:0] s2_next(input logic [7:0] old, input logic [7:0] wr);
		return {1'b0, wr[6], old[5:3] | wr[5:3], 1'b0, wr[1:0]};
	endfunction : s2_next

	function automatic logic [7:0] s3_next(input logic [7:0] old, input logic [7:0] wr);
		return {1'b0, wr[6:5], 4'h0, old[0]};
	endfunction : s3_next

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic cmd(input logic [7:0] op, input logic [7:0] d0, input int n);
		host_u.frame(op, d0, n, rd);
		repeat (10) @(posedge i_core_clk);
		#1;
	endtask : cmd

	task automatic wait_idle();
		for (int i = 0; i < 3000 && st1[0] !== 1'b0; i++) @(posedge i_core_clk);
		#1;
		check({7'h0, st1[0]}, 8'h00);
	endtask : wait_idle

	task automatic wsr(input logic [7:0] op, input logic [7:0] v);
		cmd(fsc_pkg::OP_WREN, 8'h00, 0);
		cmd(op, v, 1);
		wait_idle();
	endtask : wsr

	task automatic do_reset();
		i_rst_b = 1'b0;
		repeat (16) @(posedge i_core_clk);
		#1 i_rst_b = 1'b1;
		repeat (8) @(posedge i_core_clk);
		#1;
	endtask : do_reset

	initial begin
		#900000;
		errors++;
		conclude();
	end

	initial begin
		seed = 40686;
		errors = 0;
		tests_run = 0;
		i_wp_b = 1'b1;
		do_reset();
		check(st1, 8'h00);
		check(st2, 8'h00);
		check(st3, 8'h20);
		check({6'h0, drv}, 8'h01);
		check({7'h0, pins_on}, 8'h01);
		check({7'h0, do_oe_b}, 8'h01);
		cmd(fsc_pkg::OP_WRSR1, 8'h3C, 1);
		check(st1, 8'h00);
		cmd(fsc_pkg::OP_WREN, 8'h00, 0);
		check(st1, 8'h02);
		cmd(fsc_pkg::OP_WRDI, 8'h00, 0);
		check(st1, 8'h00);
		// Corner values first, then random guard patterns
		for (int k = 0; k < 5; k++) begin
			rnd = 8'($random(seed)) & 8'h7C;
			if (k == 0) rnd = 8'h7C;
			if (k == 1) rnd = 8'h3C;
			cmd(fsc_pkg::OP_WREN, 8'h00, 0);
			cmd(fsc_pkg::OP_WRSR1, rnd, 1);
			check(st1, rnd | 8'h01);
			cmd(fsc_pkg::OP_WREN, 8'h00, 0);
			check({7'h0, st1[1]}, 8'h00);
			wait_idle();
			check(st1, rnd);
			cmd(fsc_pkg::OP_RDSR1, 8'h00, 1);
			check(rd, rnd);
			check({7'h0, host_u.oe_seen}, 8'h01);
		end
		wsr(fsc_pkg::OP_WRSR1, 8'h80);
		@(posedge i_core_clk) #1 i_wp_b = 1'b0;
		cmd(fsc_pkg::OP_WREN, 8'h00, 0);
		cmd(fsc_pkg::OP_WRSR1, 8'h0C, 1);
		check(st1, 8'h82);
		@(posedge i_core_clk) #1 i_wp_b = 1'b1;
		cmd(fsc_pkg::OP_WRSR1, 8'h0C, 1);
		wait_idle();
		check(st1, 8'h0C);
		// Quad enable: entry refused first, then pins handed over
		cmd(fsc_pkg::OP_QUAD_ON, 8'h00, 0);
		check({7'h0, qmode}, 8'h00);
		e2 = s2_next(8'h00, 8'h7A);
		wsr(fsc_pkg::OP_WRSR2, 8'h7A);
		check(st2, e2);
		check({7'h0, pins_on}, 8'h00);
		e2 = s2_next(e2, 8'h02);
		wsr(fsc_pkg::OP_WRSR2, 8'h02);
		check(st2, e2);
		cmd(fsc_pkg::OP_RDSR2, 8'h00, 1);
		check(rd, e2);
		wsr(fsc_pkg::OP_WRSR1, 8'h80);
		@(posedge i_core_clk) #1 i_wp_b = 1'b0;
		wsr(fsc_pkg::OP_WRSR1, 8'h04);
		check(st1, 8'h04);
		@(posedge i_core_clk) #1 i_wp_b = 1'b1;
		cmd(fsc_pkg::OP_QUAD_ON, 8'h00, 0);
		check({7'h0, qmode}, 8'h01);
		wsr(fsc_pkg::OP_WRSR2, 8'h00);
		check(st2, e2);
		cmd(fsc_pkg::OP_QUAD_OFF, 8'h00, 0);
		e2 = s2_next(e2, 8'h00);
		wsr(fsc_pkg::OP_WRSR2, 8'h00);
		check({7'h0, pins_on}, 8'h01);
		// Every drive strength code, with read-only bits 4:0 written high
		e3 = 8'h20;
		for (int k = 0; k < 4; k++) begin
			rnd = {1'b0, 2'(k), 5'h1F};
			e3 = s3_next(e3, rnd);
			wsr(fsc_pkg::OP_WRSR3, rnd);
			check({6'h0, drv}, 8'(k));
			check(st3, e3);
		end
		cmd(fsc_pkg::OP_ADDR4_ON, 8'h00, 0);
		check({7'h0, st3[0]}, 8'h01);
		cmd(fsc_pkg::OP_RDSR3, 8'h00, 1);
		check(rd, e3 | 8'h01);
		cmd(fsc_pkg::OP_ADDR4_OFF, 8'h00, 0);
		check({7'h0, st3[0]}, 8'h00);
		// Suspend and resume an erase in flight
		cmd(fsc_pkg::OP_WREN, 8'h00, 0);
		cmd(fsc_pkg::OP_SEC_ERASE, 8'h00, 1);
		check({6'h0, st1[1:0]}, 8'h01);
		cmd(fsc_pkg::OP_SUSPEND, 8'h00, 0);
		check({6'h0, st2[7], st1[0]}, 8'h02);
		cmd(fsc_pkg::OP_RESUME, 8'h00, 0);
		check({6'h0, st2[7], st1[0]}, 8'h01);
		wait_idle();
		// Lockdown holds until the next power cycle
		e2 = s2_next(e2, 8'h01);
		wsr(fsc_pkg::OP_WRSR2, 8'h01);
		check(st2, e2);
		cmd(fsc_pkg::OP_WREN, 8'h00, 0);
		cmd(fsc_pkg::OP_WRSR1, 8'h10, 1);
		check(st1, 8'h06);
		do_reset();
		check(st2, 8'h00);
		host_u.seal_prefix();
		wsr(fsc_pkg::OP_WRSR1, 8'h08);
		check({7'h0, otp}, 8'h01);
		cmd(fsc_pkg::OP_WREN, 8'h00, 0);
		cmd(fsc_pkg::OP_WRSR1, 8'h00, 1);
		check(st1, 8'h0A);
		conclude();
	end
endmodule : testbench
